/* File: rtl/sap_defs.svh */
`ifndef SAP_DEFS_SVH
`define SAP_DEFS_SVH

// Timing
`define SAP_CLK_NS      10
`define SAP_MONO_NS     20000
`define SAP_MONO_CYC    (`SAP_MONO_NS / `SAP_CLK_NS)
`define SAP_MONO_W      12

// Word layout
`define SAP_ST_W        16
`define SAP_MT_W        14
`define SAP_POS_W       (`SAP_ST_W + `SAP_MT_W)
`define SAP_STD_BITS    25
`define SAP_RING_BITS   13
`define SAP_IDX_W       5
`define SAP_STD_POS     24
`define SAP_RING_POS    12

// Controller register map (APB byte addresses)
`define SAP_ADDR_W      12
`define SAP_REG_CTRL    12'h000
`define SAP_REG_DIV     12'h004
`define SAP_REG_BITS    12'h008
`define SAP_REG_STATUS  12'h00C
`define SAP_REG_DATA    12'h010

// Controller fields and reset values
`define SAP_CTRL_START  0
`define SAP_ST_BUSY     0
`define SAP_ST_DONE     1
`define SAP_ST_TAIL     2
`define SAP_DIV_W       16
`define SAP_DIV_RST     16'h0032
`define SAP_DIV_MIN     16'h0008
`define SAP_BITS_W      6
`define SAP_BITS_RST    6'h19
`define SAP_BITS_MIN    6'h01

`endif

/* File: rtl/sap_pkg.sv */
`default_nettype none
`include "sap_defs.svh"

package sap_pkg;
    typedef logic [`SAP_POS_W-1:0] sap_pos_t;
    typedef logic [`SAP_STD_BITS-1:0] sap_word_t;
    typedef logic [`SAP_IDX_W-1:0] sap_idx_t;
    typedef enum logic [1:0]
    {
        SAP_C_IDLE  = 2'b00,
        SAP_C_LOW   = 2'b01,
        SAP_C_HIGH  = 2'b11,
        SAP_C_DRAIN = 2'b10
    } sap_ctl_state_t;
endpackage

`default_nettype wire

/* File: rtl/sap_link_if.sv */
`default_nettype none

interface sap_link_if;
    logic sclk;
    logic sdata;
    modport dev (input sclk, output sdata);
    modport ctl (output sclk, input sdata);
endinterface

`default_nettype wire

/* File: rtl/sap_encoder.sv */
`default_nettype none
`include "sap_defs.svh"

module sap_encoder #(
    parameter bit GRAY_CODE  = 1'b1,
    parameter bit SHORT_WORD = 1'b0
) (
    input  wire logic              clk,
    input  wire logic              rst,
    sap_link_if.dev                link,
    input  wire sap_pkg::sap_pos_t posIn,
    input  wire logic              specialIn,
    input  wire logic              dirSelN
);
    localparam sap_pkg::sap_idx_t WordBits =
        SHORT_WORD ? `SAP_IDX_W'(`SAP_RING_BITS) : `SAP_IDX_W'(`SAP_STD_BITS);
    localparam sap_pkg::sap_idx_t TopIdx = WordBits - `SAP_IDX_W'(1);
    localparam bit RingOn = (`SAP_STD_BITS'(WordBits) <= `SAP_STD_BITS'(`SAP_RING_BITS));

    // ---------------- System clock side: code, monoflop, data pin ----------------
    logic                       dirSync1_r;
    logic                       dirSync2_r;
    logic                       sclkSync1_r;
    logic                       sclkSync2_r;
    logic                       sclkSync3_r;
    logic                       bitSync1_r;
    logic                       bitSync2_r;
    logic                       outBit_r;
    logic                       idle_r;
    logic                       risen_r;
    logic                       sdata_r;
    logic [`SAP_MONO_W-1:0]     mono_r;
    sap_pkg::sap_word_t         snap_r;

    wire sap_pkg::sap_pos_t     codeBin;
    wire sap_pkg::sap_pos_t     codeOut;
    wire sap_pkg::sap_word_t    wordNow;
    wire                        fallEv;
    wire                        riseEv;
    wire                        monoEnd;

    assign codeBin = dirSync2_r ? posIn : ~posIn;
    assign codeOut = GRAY_CODE ? (codeBin ^ (codeBin >> 1)) : codeBin;
    assign wordNow = SHORT_WORD
        ? {{(`SAP_STD_BITS - `SAP_RING_BITS){1'b0}}, codeOut[`SAP_RING_POS-1:0], specialIn}
        : {codeOut[`SAP_STD_POS-1:0], specialIn};
    assign fallEv  = sclkSync3_r & ~sclkSync2_r;
    assign riseEv  = ~sclkSync3_r & sclkSync2_r;
    assign monoEnd = (mono_r == `SAP_MONO_W'(1)) & ~fallEv;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dirSync1_r  <= 1'b1;
            dirSync2_r  <= 1'b1;
            sclkSync1_r <= 1'b1;
            sclkSync2_r <= 1'b1;
            sclkSync3_r <= 1'b1;
            bitSync1_r  <= 1'b1;
            bitSync2_r  <= 1'b1;
        end
        else
        begin
            dirSync1_r  <= dirSelN;
            dirSync2_r  <= dirSync1_r;
            sclkSync1_r <= link.sclk;
            sclkSync2_r <= sclkSync1_r;
            sclkSync3_r <= sclkSync2_r;
            bitSync1_r  <= outBit_r;
            bitSync2_r  <= bitSync1_r;
        end
    end

    // Monoflop: reloaded by every falling edge, idle again once it runs out
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mono_r <= '0;
            idle_r <= 1'b1;
        end
        else if (fallEv)
        begin
            mono_r <= `SAP_MONO_W'(`SAP_MONO_CYC);
            idle_r <= 1'b0;
        end
        else if (monoEnd)
        begin
            mono_r <= '0;
            idle_r <= 1'b1;
        end
        else if (mono_r != '0)
        begin
            mono_r <= mono_r - `SAP_MONO_W'(1);
        end
    end

    // Snapshot tracks the shaft only while idle, so it is quiet during a burst
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            snap_r <= '0;
        end
        else if (idle_r)
        begin
            snap_r <= wordNow;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            risen_r <= 1'b0;
            sdata_r <= 1'b1;
        end
        else
        begin
            risen_r <= idle_r ? 1'b0 : (risen_r | riseEv);
            // High at rest and before the first rising edge, low tail after a standard word until timeout; the ring word repeats instead
            sdata_r <= (idle_r | ~risen_r) ? 1'b1 : bitSync2_r;
        end
    end

    assign link.sdata = sdata_r;

    // ---------------- Link clock side: latch and shift ----------------
    // Unless the last burst ended with data high (possible for a ring word or bits_r below 25), idle_r is held
    // high for at least four clock cycles before the first falling edge of a burst, because the controller waits for data high.
    logic                       fresh_r;
    sap_pkg::sap_idx_t          idx_r;
    sap_pkg::sap_word_t         capWord_r;

    wire sap_pkg::sap_idx_t     idxNxt;
    wire sap_pkg::sap_idx_t     selIdx;
    wire                        bitNxt;

    always_ff @(negedge link.sclk)
    begin
        fresh_r <= idle_r;
        if (idle_r)
        begin
            capWord_r <= snap_r;
        end
    end

    assign idxNxt = fresh_r ? '0
        : (idx_r == TopIdx) ? (RingOn ? '0 : WordBits)
        : (idx_r == WordBits) ? WordBits
        : idx_r + `SAP_IDX_W'(1);
    assign selIdx = TopIdx - idxNxt;
    assign bitNxt = (idxNxt < WordBits) ? capWord_r[selIdx] : 1'b0;

    always_ff @(posedge link.sclk)
    begin
        idx_r    <= idxNxt;
        outBit_r <= bitNxt;
    end
endmodule

`default_nettype wire

/* File: rtl/sap_controller.sv */
`default_nettype none
`include "sap_defs.svh"

module sap_controller (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic [`SAP_ADDR_W-1:0] paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic [31:0]                 prdata,
    output logic                        pready,
    output logic                        pslverr,
    sap_link_if.ctl                     link
);
    sap_pkg::sap_ctl_state_t    state_r;
    logic                       sclk_r;
    logic                       dSync1_r;
    logic                       dSync2_r;
    logic [`SAP_DIV_W-1:0]      div_r;
    logic [`SAP_DIV_W-1:0]      tick_r;
    logic [`SAP_BITS_W-1:0]     bits_r;
    logic [`SAP_BITS_W:0]       cnt_r;
    logic [31:0]                rx_r;
    logic                       tail_r;
    logic                       done_r;
    logic [31:0]                prdata_r;
    logic                       pready_r;
    logic                       pslverr_r;

    wire setup     = psel & ~penable & ~pready_r;
    wire wrDone    = psel & penable & pready_r & pwrite;
    wire hitCtrl   = (paddr == `SAP_REG_CTRL);
    wire hitDiv    = (paddr == `SAP_REG_DIV);
    wire hitBits   = (paddr == `SAP_REG_BITS);
    wire hitStat   = (paddr == `SAP_REG_STATUS);
    wire hitData   = (paddr == `SAP_REG_DATA);
    wire mapped    = hitCtrl | hitDiv | hitBits | hitStat | hitData;
    wire startReq  = wrDone & hitCtrl & pwdata[`SAP_CTRL_START];
    wire doneClr   = wrDone & hitStat & pwdata[`SAP_ST_DONE];
    wire busy      = (state_r != sap_pkg::SAP_C_IDLE);
    wire tickEnd   = (tick_r == `SAP_DIV_W'(1));
    wire lastCyc   = (cnt_r == (`SAP_BITS_W+1)'(1));
    wire drainEnd  = (state_r == sap_pkg::SAP_C_DRAIN) & dSync2_r;
    wire [`SAP_DIV_W-1:0] divWr = (pwdata[`SAP_DIV_W-1:0] < `SAP_DIV_MIN)
        ? `SAP_DIV_MIN : pwdata[`SAP_DIV_W-1:0];
    wire [`SAP_BITS_W-1:0] bitsWr = (pwdata[`SAP_BITS_W-1:0] < `SAP_BITS_MIN)
        ? `SAP_BITS_MIN : pwdata[`SAP_BITS_W-1:0];
    wire [31:0] statWord = {29'h0, tail_r, done_r, busy};
    wire [31:0] rdMux = hitCtrl ? 32'h0
        : hitDiv  ? {16'h0, div_r}
        : hitBits ? {26'h0, bits_r}
        : hitStat ? statWord
        : hitData ? rx_r
        : 32'h0;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end
        else
        begin
            pready_r  <= setup;
            pslverr_r <= setup & ~mapped;
            prdata_r  <= (setup & ~pwrite) ? rdMux : 32'h0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            div_r  <= `SAP_DIV_RST;
            bits_r <= `SAP_BITS_RST;
            done_r <= 1'b0;
        end
        else
        begin
            if (wrDone & hitDiv)
            begin
                div_r <= divWr;
            end
            if (wrDone & hitBits)
            begin
                bits_r <= bitsWr;
            end
            done_r <= drainEnd | (done_r & ~doneClr);
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            dSync1_r <= 1'b1;
            dSync2_r <= 1'b1;
        end
        else
        begin
            dSync1_r <= link.sdata;
            dSync2_r <= dSync1_r;
        end
    end

    // Burst: bits_r sampled periods plus one trailing period whose bit goes to tail_r
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r <= sap_pkg::SAP_C_IDLE;
            sclk_r  <= 1'b1;
            tick_r  <= '0;
            cnt_r   <= '0;
            rx_r    <= 32'h0;
            tail_r  <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                sap_pkg::SAP_C_IDLE:
                begin
                    sclk_r <= 1'b1;
                    if (startReq & dSync2_r)
                    begin
                        state_r <= sap_pkg::SAP_C_LOW;
                        sclk_r  <= 1'b0;
                        tick_r  <= div_r;
                        cnt_r   <= {1'b0, bits_r} + (`SAP_BITS_W+1)'(1);
                    end
                end
                sap_pkg::SAP_C_LOW:
                begin
                    if (tickEnd)
                    begin
                        state_r <= sap_pkg::SAP_C_HIGH;
                        sclk_r  <= 1'b1;
                        tick_r  <= div_r;
                    end
                    else
                    begin
                        tick_r <= tick_r - `SAP_DIV_W'(1);
                    end
                end
                sap_pkg::SAP_C_HIGH:
                begin
                    if (tickEnd & lastCyc)
                    begin
                        tail_r  <= dSync2_r;
                        state_r <= sap_pkg::SAP_C_DRAIN;
                    end
                    else if (tickEnd)
                    begin
                        rx_r    <= {rx_r[30:0], dSync2_r};
                        state_r <= sap_pkg::SAP_C_LOW;
                        sclk_r  <= 1'b0;
                        tick_r  <= div_r;
                        cnt_r   <= cnt_r - (`SAP_BITS_W+1)'(1);
                    end
                    else
                    begin
                        tick_r <= tick_r - `SAP_DIV_W'(1);
                    end
                end
                sap_pkg::SAP_C_DRAIN:
                begin
                    if (dSync2_r)
                    begin
                        state_r <= sap_pkg::SAP_C_IDLE;
                    end
                end
            endcase
        end
    end

    assign prdata    = prdata_r;
    assign pready    = pready_r;
    assign pslverr   = pslverr_r;
    assign link.sclk = sclk_r;
endmodule

`default_nettype wire

/* File: dv/sap_link_monitor.sv */
`default_nettype none

module sap_link_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic sclk,
    input wire logic sdata
);
    logic [11:0] idleCnt;
    logic [4:0]  bitCnt;
    logic        sclkQ;
    wire         fallNow;
    wire         longIdle;

    assign fallNow  = sclkQ && !sclk;
    assign longIdle = idleCnt > 12'h0C8;

    // Cycles since the link clock was last low, saturating
    always_ff @(posedge clk)
    begin
        sclkQ <= sclk;
        if (rst)
            idleCnt <= 12'hFFF;
        else if (!sclk)
            idleCnt <= 12'h000;
        else if (idleCnt != 12'hFFF)
            idleCnt <= idleCnt + 12'h001;
    end

    // Falls within one burst; a fall after a long idle starts a new count
    always_ff @(posedge clk)
    begin
        if (fallNow)
            bitCnt <= longIdle ? 5'h01 : bitCnt + 5'h01;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_reset_idle: assert property (disable iff (1'b0) rst ##1 rst |-> sclk && sdata)
        else $error("link lines not high during reset");
    a_start_high: assert property (fallNow && longIdle |-> sdata)
        else $error("burst started while data low");
    a_first_hold: assert property (fallNow && longIdle |=> sdata [*8])
        else $error("data left high before first rise");
    a_bit_change: assert property ($changed(sdata) |->
        (sclk && idleCnt < 12'h006) || (idleCnt > 12'h76C && idleCnt < 12'h834))
        else $error("data changed away from a rising edge");
    a_tail_low: assert property ($rose(sclk) && bitCnt == 5'h1A |-> ##5 !sdata)
        else $error("data not low after last bit");
    a_mono_hold: assert property (idleCnt > 12'h028 && idleCnt < 12'h76C |-> !sdata)
        else $error("data rose before monoflop end");
    a_mono_end: assert property (idleCnt > 12'h834 |-> sdata)
        else $error("data still low after monoflop");
    a_word_bits: assert property (idleCnt == 12'h3E8 |-> bitCnt == 5'h1A)
        else $error("burst length not 26 clocks");

    c_burst_start: cover property (fallNow && longIdle);
    c_tail_rise: cover property ($rose(sclk) && bitCnt == 5'h1A);
    c_mono_end: cover property ($rose(sdata) && idleCnt > 12'h76C);
endmodule

`default_nettype wire

/* File: dv/ssi_absolute_position_slave_bench.sv */
`default_nettype none
`include "sap_defs.svh"

module ssi_absolute_position_slave_bench;
    timeunit 1ns;
    timeprecision 1ps;

    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [11:0]       paddr = 12'h000;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [31:0]       pwdata = 32'h0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    sap_pkg::sap_pos_t posIn = '0;
    logic              specialIn = 1'b0;
    logic              dirSelN = 1'b1;
    logic [31:0]       rnd = 32'h4AE2B6BA;
    logic [31:0]       rdat;
    logic              rerr;
    logic [31:0]       prdata2;
    logic              pready2;
    logic              pslverr2;
    logic [31:0]       rdat2;
    logic              rerr2;
    int                nFail = 0;
    int                cmpCount = 0;
    int                cyc = 0;

    always #5 clk = ~clk;

    sap_link_if link ();

    sap_encoder #(.GRAY_CODE(1'b0), .SHORT_WORD(1'b0)) u_sap_encoder (
        .clk(clk), .rst(rst), .link(link),
        .posIn(posIn), .specialIn(specialIn), .dirSelN(dirSelN));

    sap_controller u_sap_controller (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link));

    // Second pair on the same bus: Gray code, 13-bit ring word
    sap_link_if ringLink ();

    sap_encoder #(.GRAY_CODE(1'b1), .SHORT_WORD(1'b1)) u_sap_encoder_ring (
        .clk(clk), .rst(rst), .link(ringLink),
        .posIn(posIn), .specialIn(specialIn), .dirSelN(dirSelN));

    sap_controller u_sap_controller_ring (
        .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata2), .pready(pready2),
        .pslverr(pslverr2), .link(ringLink));

    sap_link_monitor u_sap_link_monitor (
        .clk(clk), .rst(rst), .sclk(link.sclk), .sdata(link.sdata));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Low direction input sends the complemented position, special bit last
    function automatic logic [24:0] expWord(input logic [29:0] p, input logic s, input logic d);
        return {d ? p[23:0] : ~p[23:0], s};
    endfunction

    // Ring build: Gray code of the direction-adjusted position, low 12 bits, special last
    function automatic logic [12:0] ringWord(input logic [29:0] p, input logic s, input logic d);
        logic [29:0] b;
        b = d ? p : ~p;
        return {b[11:0] ^ b[12:1], s};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmpCount++;
        if (got !== exp)
        begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            nFail++;
        end
    endtask

    task automatic wrapUp();
        $display("Comparisons %0d, mismatches %0d", cmpCount, nFail);
        if (nFail == 0 && cmpCount > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while ({pready, pready2} !== 2'b11)
        begin
            @(posedge clk);
        end
        rdat = prdata;
        rdat2 = prdata2;
        rerr = pslverr;
        rerr2 = pslverr2;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // One burst; inputs change mid-burst, the latched word must not
    task automatic burst(input logic [29:0] p, input logic s, input logic d);
        int n;
        logic [12:0] w;
        w = ringWord(p, s, d);
        posIn <= p;
        specialIn <= s;
        dirSelN <= d;
        repeat (8) @(posedge clk);
        apb(1'b1, `SAP_REG_CTRL, 32'h1);
        repeat (100) @(posedge clk);
        posIn <= ~p;
        specialIn <= ~s;
        dirSelN <= ~d;
        n = 0;
        do
        begin
            apb(1'b0, `SAP_REG_STATUS, 32'h0);
            n++;
        end
        while (rdat[1] !== 1'b1 && n < 1000);
        apb(1'b0, `SAP_REG_DATA, 32'h0);
        chk(32'(rdat[24:0]), 32'(expWord(p, s, d)));
        chk(32'(rdat2[24:0]), 32'({w, w[12:1]}));
        apb(1'b0, `SAP_REG_STATUS, 32'h0);
        chk(32'(rdat[2:0]), 32'h2);
        chk(32'(rdat2[2:0]), 32'({w[0], 2'b10}));
        apb(1'b1, `SAP_REG_STATUS, 32'h2);
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 40000)
        begin
            nFail++;
            wrapUp();
        end
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        apb(1'b0, `SAP_REG_DIV, 32'h0);
        chk(rdat, 32'h32);
        apb(1'b0, `SAP_REG_BITS, 32'h0);
        chk(rdat, 32'h19);
        apb(1'b0, `SAP_REG_STATUS, 32'h0);
        chk(rdat, 32'h0);
        apb(1'b0, 12'h020, 32'h0);
        chk(32'(rerr), 32'h1);
        chk(32'(rerr2), 32'h1);
        chk(rdat, 32'h0);
        $display("Test registers done");
        apb(1'b1, `SAP_REG_DIV, 32'h3);
        apb(1'b0, `SAP_REG_DIV, 32'h0);
        chk(rdat, 32'h8);
        apb(1'b1, `SAP_REG_BITS, 32'h0);
        apb(1'b0, `SAP_REG_BITS, 32'h0);
        chk(rdat, 32'h1);
        apb(1'b1, `SAP_REG_BITS, 32'h19);
        $display("Test clamps done");
        burst(30'h3FFFFFFF, 1'b0, 1'b1);
        burst(30'h00000000, 1'b1, 1'b0);
        $display("Test corner words done");
        for (int i = 0; i < 4; i++)
        begin
            rnd = lfsr(rnd);
            burst(rnd[29:0], rnd[31], rnd[30]);
        end
        $display("Test random words done");
        wrapUp();
    end
endmodule

`default_nettype wire
